// ==== design/ews_bus_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_defines.svh"
// one strobed read or write cycle on the flash pins
module ews_bus_cycle (
   input  wire logic        i_clk,     // clock
   input  wire logic        i_resetn,  // async reset, active low
   input  wire logic        i_start,   // start one cycle
   input  wire logic        i_write,   // 1 write, 0 read
   input  wire logic [18:0] i_addr,    // address
   input  wire logic [7:0]  i_wdata,   // write data
   input  wire logic [7:0]  i_dq_in,   // data pins in
   output logic      [18:0] o_addr,    // address pins
   output logic      [7:0]  o_dq_out,  // data pins out
   output logic             o_dq_oe,   // data pin drive
   output logic             o_ce_n,    // chip enable
   output logic             o_oe_n,    // output enable
   output logic             o_we_n,    // write enable
   output logic             o_done,    // cycle done pulse
   output logic      [7:0]  o_rdata    // captured read data
);
   logic [2:0] cnt;
   logic       busy;
   logic       wr;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         busy     <= 1'b0;
         cnt      <= 3'h0;
         wr       <= 1'b0;
         o_addr   <= 19'h00000;
         o_dq_out <= 8'h00;
         o_dq_oe  <= 1'b0;
         o_ce_n   <= 1'b1;
         o_oe_n   <= 1'b1;
         o_we_n   <= 1'b1;
         o_done   <= 1'b0;
         o_rdata  <= 8'h00;
      end
      else
      begin
         o_done <= 1'b0;
         if (!busy && i_start)
         begin
            busy     <= 1'b1;
            cnt      <= `EWS_BUS_CYC;
            wr       <= i_write;
            o_addr   <= i_addr;
            o_dq_out <= i_wdata;
            o_dq_oe  <= i_write;
            o_ce_n   <= 1'b0;
            o_oe_n   <= i_write;
            o_we_n   <= !i_write;
         end
         else if (busy)
         begin
            if (cnt == 3'h0)
            begin
               busy    <= 1'b0;
               o_done  <= 1'b1;
               o_ce_n  <= 1'b1;
               o_oe_n  <= 1'b1;
               o_we_n  <= 1'b1;
               o_dq_oe <= 1'b0;
               if (!wr)
               begin
                  o_rdata <= i_dq_in;
               end
            end
            else
            begin
               cnt <= cnt - 3'h1;
            end
         end
      end
   end
endmodule : ews_bus_cycle
`default_nettype wire

// ==== design/ews_defines.svh ====
`ifndef EWS_DEFINES_SVH
`define EWS_DEFINES_SVH
// software register offsets
`define EWS_REG_CTRL     4'h0
`define EWS_REG_ADDR     4'h1
`define EWS_REG_DATA     4'h2
`define EWS_REG_STATUS   4'h3
`define EWS_REG_IRQ_STAT 4'h4
`define EWS_REG_IRQ_MASK 4'h5
`define EWS_REG_LAST     4'h6
// ctrl fields (write one to start)
`define EWS_CTRL_PROG    0
`define EWS_CTRL_SECT    1
`define EWS_CTRL_CHIP    2
`define EWS_CTRL_MORE    3
`define EWS_CTRL_SUSP    4
`define EWS_CTRL_RESUME  5
`define EWS_CTRL_RESET   6
// status fields
`define EWS_ST_BUSY      0
`define EWS_ST_DONE      1
`define EWS_ST_FAIL      2
`define EWS_ST_TIMER     3
`define EWS_ST_NOT_ACC   4
// irq fields
`define EWS_IRQ_DONE     0
`define EWS_IRQ_FAIL     1
`define EWS_IRQ_NOT_ACC  2
// data bus bit positions
`define EWS_DQ_POLL      7
`define EWS_DQ_TOG1      6
`define EWS_DQ_TLF       5
`define EWS_DQ_ETMR      3
`define EWS_DQ_TOG2      2
// bus timing, cycles at 20 MHz
`define EWS_BUS_CYC      3'h3
// unlock addresses and command codes
`define EWS_UNL_A1       19'h00555
`define EWS_UNL_A2       19'h002aa
`define EWS_UNL_D1       8'haa
`define EWS_UNL_D2       8'h55
`define EWS_CMD_PROG     8'ha0
`define EWS_CMD_ERASE    8'h80
`define EWS_CMD_CHIP     8'h10
`define EWS_CMD_SECT     8'h30
`define EWS_CMD_SUSP     8'hb0
`define EWS_CMD_RESUME   8'h30
`define EWS_CMD_RESET    8'hf0
`endif

// ==== design/ews_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_defines.svh"
module ews_host (
   input  wire logic        i_clk,      // 20 MHz clock
   input  wire logic        i_resetn,   // async reset, active low
   input  wire logic [3:0]  i_addr,     // register address
   input  wire logic [31:0] i_wdata,    // register write data
   input  wire logic        i_wr,       // write strobe
   input  wire logic        i_rd,       // read strobe
   output logic      [31:0] o_rdata,    // read data, cycle after strobe
   output logic             o_irq,      // level interrupt
   output logic      [18:0] o_fl_addr,  // flash address
   input  wire logic [7:0]  i_fl_dq,    // flash data in
   output logic      [7:0]  o_fl_dq,    // flash data out
   output logic             o_fl_dq_oe, // flash data drive
   output logic             o_fl_ce_n,  // flash chip enable
   output logic             o_fl_oe_n,  // flash output enable
   output logic             o_fl_we_n   // flash write enable
);
   ews_pkg::ews_state_t state;
   ews_pkg::ews_op_t    op;
   logic [18:0] tgt_addr;
   logic [7:0]  tgt_data;
   logic [2:0]  seq_idx;
   logic [2:0]  seq_len;
   logic [7:0]  first_rd;
   logic        busy;
   logic        done_st;
   logic        fail_st;
   logic        timer_st;
   logic        not_acc_st;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic [2:0]  irq_set;
   logic        bc_start;
   logic        bc_write;
   logic [18:0] bc_addr;
   logic [7:0]  bc_wdata;
   logic        bc_done;
   logic [7:0]  bc_rdata;
   logic        ctrl_wr;
   logic [26:0] seq_w;

   // unlock and command sequence word per op and step
   function automatic logic [26:0] seq_word(input ews_pkg::ews_op_t o, input logic [2:0] i,
                                            input logic [18:0] a, input logic [7:0] d);
      logic [26:0] w;
      w = {`EWS_UNL_A1, `EWS_CMD_RESET};
      unique case (i)
         3'h0: w = (o == ews_pkg::OP_SUSP) ? {a, `EWS_CMD_SUSP} :
                   (o == ews_pkg::OP_RES)  ? {a, `EWS_CMD_RESUME} :
                   (o == ews_pkg::OP_RST)  ? {a, `EWS_CMD_RESET} :
                   (o == ews_pkg::OP_MORE) ? {a, `EWS_CMD_SECT} :
                   {`EWS_UNL_A1, `EWS_UNL_D1};
         3'h1: w = {`EWS_UNL_A2, `EWS_UNL_D2};
         3'h2: w = (o == ews_pkg::OP_PROG) ? {`EWS_UNL_A1, `EWS_CMD_PROG} :
                   {`EWS_UNL_A1, `EWS_CMD_ERASE};
         3'h3: w = (o == ews_pkg::OP_PROG) ? {a, d} : {`EWS_UNL_A1, `EWS_UNL_D1};
         3'h4: w = {`EWS_UNL_A2, `EWS_UNL_D2};
         default: w = (o == ews_pkg::OP_CHIP) ? {`EWS_UNL_A1, `EWS_CMD_CHIP} :
                      {a, `EWS_CMD_SECT};
      endcase
      return w;
   endfunction : seq_word

   function automatic logic [2:0] seq_count(input ews_pkg::ews_op_t o);
      unique case (o)
         ews_pkg::OP_PROG: return 3'h4;
         ews_pkg::OP_SECT,
         ews_pkg::OP_CHIP: return 3'h6;
         default:          return 3'h1;
      endcase
   endfunction : seq_count

   assign ctrl_wr  = i_wr && (i_addr == `EWS_REG_CTRL) && !busy;
   assign bc_write = (state == ews_pkg::ST_WSEQ);
   assign bc_start = (state != ews_pkg::ST_IDLE) && !bc_done;
   // status reads always at the target address
   // valid status address
   assign seq_w    = seq_word(op, seq_idx, tgt_addr, tgt_data);
   assign bc_addr  = bc_write ? seq_w[26:8] : tgt_addr;
   assign bc_wdata = seq_w[7:0];
   assign busy     = (state != ews_pkg::ST_IDLE);

   ews_bus_cycle u_bus (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_start  (bc_start),
      .i_write  (bc_write),
      .i_addr   (bc_addr),
      .i_wdata  (bc_wdata),
      .i_dq_in  (i_fl_dq),
      .o_addr   (o_fl_addr),
      .o_dq_out (o_fl_dq),
      .o_dq_oe  (o_fl_dq_oe),
      .o_ce_n   (o_fl_ce_n),
      .o_oe_n   (o_fl_oe_n),
      .o_we_n   (o_fl_we_n),
      .o_done   (bc_done),
      .o_rdata  (bc_rdata)
   );

   // sequencer
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state      <= ews_pkg::ST_IDLE;
         op         <= ews_pkg::OP_RST;
         seq_idx    <= 3'h0;
         seq_len    <= 3'h1;
         first_rd   <= 8'h00;
         done_st    <= 1'b0;
         fail_st    <= 1'b0;
         timer_st   <= 1'b0;
         not_acc_st <= 1'b0;
         irq_set    <= 3'h0;
      end
      else
      begin
         irq_set <= 3'h0;
         unique case (state)
            ews_pkg::ST_IDLE:
            begin
               if (ctrl_wr)
               begin
                  op      <= ews_pkg::OP_RST;
                  seq_len <= seq_count(ews_pkg::OP_RST);
                  if (i_wdata[`EWS_CTRL_PROG])
                  begin
                     op      <= ews_pkg::OP_PROG;
                     seq_len <= seq_count(ews_pkg::OP_PROG);
                  end
                  else if (i_wdata[`EWS_CTRL_SECT])
                  begin
                     op      <= ews_pkg::OP_SECT;
                     seq_len <= seq_count(ews_pkg::OP_SECT);
                  end
                  else if (i_wdata[`EWS_CTRL_CHIP])
                  begin
                     op      <= ews_pkg::OP_CHIP;
                     seq_len <= seq_count(ews_pkg::OP_CHIP);
                  end
                  else if (i_wdata[`EWS_CTRL_MORE])
                  begin
                     op      <= ews_pkg::OP_MORE;
                     seq_len <= seq_count(ews_pkg::OP_MORE);
                  end
                  else if (i_wdata[`EWS_CTRL_SUSP])
                  begin
                     op      <= ews_pkg::OP_SUSP;
                     seq_len <= seq_count(ews_pkg::OP_SUSP);
                  end
                  else if (i_wdata[`EWS_CTRL_RESUME])
                  begin
                     op      <= ews_pkg::OP_RES;
                     seq_len <= seq_count(ews_pkg::OP_RES);
                  end
                  seq_idx    <= 3'h0;
                  done_st    <= 1'b0;
                  fail_st    <= 1'b0;
                  not_acc_st <= 1'b0;
                  state <= i_wdata[`EWS_CTRL_MORE] && !(|i_wdata[2:0]) ?
                           ews_pkg::ST_MCHK1 : ews_pkg::ST_WSEQ;
               end
            end
            ews_pkg::ST_MCHK1:
            begin
               if (bc_done)
               begin
                  timer_st <= bc_rdata[`EWS_DQ_ETMR];
                  if (bc_rdata[`EWS_DQ_ETMR])
                  begin
                     not_acc_st <= 1'b1;
                     irq_set    <= 3'h4;
                     state      <= ews_pkg::ST_IDLE;
                  end
                  else
                  begin
                     state <= ews_pkg::ST_WSEQ;
                  end
               end
            end
            ews_pkg::ST_WSEQ:
            begin
               if (bc_done)
               begin
                  seq_idx <= seq_idx + 3'h1;
                  if (seq_idx == seq_len - 3'h1)
                  begin
                     unique case (op)
                        ews_pkg::OP_MORE: state <= ews_pkg::ST_MCHK2;
                        ews_pkg::OP_PROG,
                        ews_pkg::OP_SECT,
                        ews_pkg::OP_CHIP: state <= ews_pkg::ST_POLL1;
                        default:
                        begin
                           state   <= ews_pkg::ST_IDLE;
                           done_st <= 1'b1;
                           timer_st <= 1'b0;
                        end
                     endcase
                  end
                  else if (op == ews_pkg::OP_PROG && seq_idx == 3'h2)
                  begin
                     // program word carries data from the data register
                     seq_idx <= 3'h3;
                  end
                  else if (op != ews_pkg::OP_PROG && seq_idx == 3'h2)
                  begin
                     seq_idx <= 3'h3;
                  end
               end
            end
            ews_pkg::ST_MCHK2:
            begin
               if (bc_done)
               begin
                  // high after add means maybe refused
                  timer_st <= bc_rdata[`EWS_DQ_ETMR];
                  if (bc_rdata[`EWS_DQ_ETMR])
                  begin
                     not_acc_st <= 1'b1;
                     irq_set    <= 3'h4;
                  end
                  state <= ews_pkg::ST_IDLE;
               end
            end
            ews_pkg::ST_POLL1:
            begin
               if (bc_done)
               begin
                  first_rd <= bc_rdata;
                  state    <= ews_pkg::ST_POLL2;
               end
            end
            ews_pkg::ST_POLL2:
            begin
               if (bc_done)
               begin
                  first_rd <= bc_rdata;
                  if (bc_rdata[`EWS_DQ_TOG1] == first_rd[`EWS_DQ_TOG1])
                  begin
                     state   <= ews_pkg::ST_IDLE;
                     done_st <= 1'b1;
                     irq_set <= 3'h1;
                  end
                  else if (bc_rdata[`EWS_DQ_TLF])
                  begin
                     state <= ews_pkg::ST_FAILCK;
                  end
                  else if (op == ews_pkg::OP_SECT && !timer_st)
                  begin
                     state <= ews_pkg::ST_TMRCK;
                  end
                  else
                  begin
                     state <= ews_pkg::ST_POLL2;
                  end
               end
            end
            ews_pkg::ST_TMRCK:
            begin
               if (bc_done)
               begin
                  timer_st <= bc_rdata[`EWS_DQ_ETMR];
                  first_rd <= bc_rdata;
                  state    <= ews_pkg::ST_POLL2;
               end
            end
            ews_pkg::ST_FAILCK:
            begin
               if (bc_done)
               begin
                  if (bc_rdata[`EWS_DQ_TOG1] == first_rd[`EWS_DQ_TOG1])
                  begin
                     done_st <= 1'b1;
                     irq_set <= 3'h1;
                  end
                  else
                  begin
                     fail_st <= 1'b1;
                     irq_set <= 3'h2;
                  end
                  state <= ews_pkg::ST_IDLE;
               end
            end
            default: state <= ews_pkg::ST_IDLE;
         endcase
      end
   end

   // interrupt status, set wins over clear
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
      end
      else
      begin
         if (i_wr && i_addr == `EWS_REG_IRQ_MASK)
         begin
            irq_mask <= i_wdata[2:0];
         end
         if (i_wr && i_addr == `EWS_REG_IRQ_STAT)
         begin
            irq_stat <= (irq_stat & ~i_wdata[2:0]) | irq_set;
         end
         else
         begin
            irq_stat <= irq_stat | irq_set;
         end
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   // register writes of address and data
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tgt_addr <= 19'h00000;
         tgt_data <= 8'h00;
      end
      else if (i_wr && !busy)
      begin
         if (i_addr == `EWS_REG_ADDR)
         begin
            tgt_addr <= i_wdata[18:0];
         end
         if (i_addr == `EWS_REG_DATA)
         begin
            tgt_data <= i_wdata[7:0];
         end
      end
   end

   // read data one cycle after strobe
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 32'h00000000;
      end
      else if (i_rd)
      begin
         unique case (i_addr)
            `EWS_REG_ADDR:     o_rdata <= {13'h0000, tgt_addr};
            `EWS_REG_DATA:     o_rdata <= {24'h000000, tgt_data};
            `EWS_REG_STATUS:   o_rdata <= {27'h0000000, not_acc_st, timer_st,
                                           fail_st, done_st, busy};
            `EWS_REG_IRQ_STAT: o_rdata <= {29'h00000000, irq_stat};
            `EWS_REG_IRQ_MASK: o_rdata <= {29'h00000000, irq_mask};
            `EWS_REG_LAST:     o_rdata <= {24'h000000, first_rd};
            default:           o_rdata <= 32'h00000000;
         endcase
      end
      else
      begin
         o_rdata <= 32'h00000000;
      end
   end
endmodule : ews_host
`default_nettype wire

// ==== design/ews_pkg.sv ====
`default_nettype none
package ews_pkg;
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_WSEQ   = 4'h1,
      ST_CHK1   = 4'h2,
      ST_POLL1  = 4'h3,
      ST_POLL2  = 4'h4,
      ST_FAILCK = 4'h5,
      ST_TMRCK  = 4'h6,
      ST_MCHK1  = 4'h7,
      ST_MCHK2  = 4'h8
   } ews_state_t;
   typedef enum logic [2:0] {
      OP_PROG  = 3'h0,
      OP_SECT  = 3'h1,
      OP_CHIP  = 3'h2,
      OP_MORE  = 3'h3,
      OP_SUSP  = 3'h4,
      OP_RES   = 3'h5,
      OP_RST   = 3'h6
   } ews_op_t;
endpackage : ews_pkg
`default_nettype wire

// ==== dv/ews_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ews_flash_model (
   input  wire logic [7:0] i_dq,   // data from host
   input  wire logic       i_ce_n, // chip enable
   input  wire logic       i_oe_n, // output enable
   input  wire logic       i_we_n, // write enable
   input  wire logic       i_fail, // overrun the running op
   input  wire logic [7:0] i_win,  // window length in reads
   output logic      [7:0] o_dq    // data to host
);
   logic [7:0] prev, pdat, last, cnt, win;
   logic       busy, prog, tmr, tog, fl, susp;
   initial
   begin
      {prev, last, cnt, win} = 32'h0;
      pdat = 8'hff;
      {busy, prog, tmr, tog, fl, susp} = 6'h0;
   end
   // released bus shows the inverse of the last value
   assign o_dq = (!i_ce_n && !i_oe_n) ? last : ~last;
   always @(negedge i_we_n)
   begin
      #1;
      if (i_dq == 8'hf0)
         {busy, prog, tmr, fl, susp} = 5'h0;
      // more sectors only while window runs
      else if (busy)
      begin
         // suspend shows array data until resume
         if (!prog && i_dq == 8'hb0)
            susp = 1'b1;
         else if (susp && i_dq == 8'h30)
            susp = 1'b0;
         else if (!prog && !tmr && i_dq == 8'h30)
            win = i_win;
      end
      // program takes the byte after its code
      else if (prev == 8'ha0)
         {busy, prog, pdat, cnt, win} = {2'h3, i_dq, 8'h3, 8'h0};
      // only sector erase opens the window
      else if (prev == 8'h55 && (i_dq == 8'h30 || i_dq == 8'h10))
         {busy, prog, tmr, win, cnt, pdat} =
            {2'h2, i_dq == 8'h10, i_dq == 8'h10 ? 8'h0 : i_win, 8'h3, 8'hff};
      prev = i_dq;
   end
   always @(negedge i_oe_n)
   begin
      #1;
      if (busy && !susp)
      begin
         tog = ~tog;
         // overrun shows on the fail bit
         fl = i_fail;
         if (win != 8'h0)
            win = win - 8'h1;
         else
         begin
            tmr = !prog;
            if (!fl)
               cnt = cnt - 8'h1;
         end
         busy = cnt != 8'h0;
      end
      // complement while programming, true value after
      last = (busy && !susp) ?
             {prog ? ~pdat[7] : 1'b0, tog, fl, 1'b0, tmr, !prog & tog, 2'h0} : pdat;
   end
endmodule : ews_flash_model
`default_nettype wire

// ==== dv/ews_host_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_defines.svh"
module ews_chk (
   input  wire logic        i_clk,      // clock
   input  wire logic        i_resetn,   // reset, active low
   input  wire logic [3:0]  i_addr,     // register index
   input  wire logic [31:0] i_wdata,    // write data
   input  wire logic        i_wr,       // write strobe
   input  wire logic        i_rd,       // read strobe
   input  wire logic [31:0] o_rdata,    // read data
   input  wire logic        o_irq,      // interrupt
   input  wire logic [18:0] o_fl_addr,  // flash address
   input  wire logic [7:0]  o_fl_dq,    // flash data out
   input  wire logic        o_fl_dq_oe, // flash data drive
   input  wire logic        o_fl_ce_n,  // chip enable
   input  wire logic        o_fl_oe_n,  // output enable
   input  wire logic        o_fl_we_n   // write enable
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence pins_low_s;
      !o_fl_ce_n [*4];
   endsequence
   sequence pins_free_s;
      o_fl_ce_n && o_fl_oe_n && o_fl_we_n;
   endsequence
   cycle_len_a: assert property ($fell(o_fl_ce_n) |-> pins_low_s ##1 pins_free_s)
      else $error("flash strobe length wrong");
   strobe_excl_a: assert property (!(!o_fl_oe_n && !o_fl_we_n))
      else $error("read and write strobes together");
   no_fight_a: assert property (!o_fl_oe_n |-> !o_fl_dq_oe)
      else $error("host drives data during read");
   write_in_ce_a: assert property (!o_fl_we_n |-> !o_fl_ce_n)
      else $error("write strobe outside chip enable");
   pins_hold_a: assert property ((!o_fl_ce_n && !$fell(o_fl_ce_n))
      |-> $stable(o_fl_addr) && $stable(o_fl_dq) && $stable(o_fl_we_n))
      else $error("flash pins moved in a cycle");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   unmapped_a: assert property (i_rd && i_addr > `EWS_REG_LAST |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   irq_mask_a: assert property (i_wr && i_addr == `EWS_REG_IRQ_MASK
      && i_wdata[2:0] == 3'h0 |=> !o_irq)
      else $error("masked interrupt still high");
endmodule : ews_chk
bind ews_host ews_chk i_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_fl_addr(o_fl_addr), .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe),
   .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n));
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ews_defines.svh"
module testbench;
   logic        i_clk, i_resetn, i_wr, i_rd, m_fail;
   logic [3:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [7:0]  m_win, fl_out, fl_in, m_dq;
   logic        o_irq, fl_oe, ce_n, oe_n, we_n;
   logic [18:0] fl_addr, rd_addr;
   int          err_total, compares;
   assign fl_in = fl_oe ? fl_out : m_dq;
   ews_host i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_fl_addr(fl_addr),
      .i_fl_dq(fl_in), .o_fl_dq(fl_out), .o_fl_dq_oe(fl_oe), .o_fl_ce_n(ce_n),
      .o_fl_oe_n(oe_n), .o_fl_we_n(we_n));
   ews_flash_model i_flash (.i_dq(fl_in), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_fail(m_fail), .i_win(m_win), .o_dq(m_dq));
   always #25 i_clk = ~i_clk;
   // address of the last flash read, taken as the read strobe ends
   always @(posedge oe_n) rd_addr <= fl_addr;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clk);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   task automatic run(input int b, input logic [4:0] msk, input logic [4:0] exp);
      logic [31:0] d;
      int          n;
      wr(`EWS_REG_CTRL, 32'h1 << b);
      d = 32'h1;
      for (n = 0; n < 400 && d[`EWS_ST_BUSY] !== 1'b0; n++)
         rd(`EWS_REG_STATUS, d);
      check("status", d[4:0] & msk, exp);
   endtask : run
   task automatic t_regs;
      logic [31:0] d;
      rd(4'hf, d);
      check("unmapped", d, 32'h0);
      wr(`EWS_REG_IRQ_MASK, 32'h7);
   endtask : t_regs
   task automatic t_chip;
      run(`EWS_CTRL_CHIP, 5'h0f, 5'h02);
      wr(`EWS_REG_IRQ_STAT, 32'h7);
   endtask : t_chip
   task automatic t_prog;
      logic [31:0] d;
      wr(`EWS_REG_ADDR, 32'h1234a);
      wr(`EWS_REG_DATA, 32'h52);
      run(`EWS_CTRL_PROG, 5'h07, 5'h02);
      check("status addr", rd_addr, 32'h1234a);
      rd(`EWS_REG_LAST, d);
      check("last status", d, 32'h52);
      rd(`EWS_REG_IRQ_STAT, d);
      check("done irq", {d[0], o_irq}, 32'h3);
      wr(`EWS_REG_IRQ_STAT, 32'h7);
      check("irq clear", o_irq, 32'h0);
      run(`EWS_CTRL_MORE, 5'h13, 5'h00);
   endtask : t_prog
   task automatic t_sect;
      m_win <= 8'h3;
      run(`EWS_CTRL_SECT, 5'h1f, 5'h0a);
      wr(`EWS_REG_IRQ_STAT, 32'h7);
   endtask : t_sect
   task automatic t_more;
      logic [31:0] d;
      run(`EWS_CTRL_MORE, 5'h11, 5'h10);
      rd(`EWS_REG_IRQ_STAT, d);
      check("refused irq", d[2], 32'h1);
      wr(`EWS_REG_IRQ_MASK, 32'h0);
      check("masked", o_irq, 32'h0);
      wr(`EWS_REG_IRQ_MASK, 32'h7);
      wr(`EWS_REG_IRQ_STAT, 32'h7);
   endtask : t_more
   task automatic t_fail;
      m_fail <= 1'b1;
      run(`EWS_CTRL_PROG, 5'h05, 5'h04);
      check("fail irq", o_irq, 32'h1);
      m_fail <= 1'b0;
      wr(`EWS_REG_IRQ_STAT, 32'h7);
   endtask : t_fail
   task automatic t_single;
      run(`EWS_CTRL_RESET, 5'h01, 5'h00);
      run(`EWS_CTRL_SUSP, 5'h01, 5'h00);
      run(`EWS_CTRL_RESUME, 5'h01, 5'h00);
      check("no irq", o_irq, 32'h0);
   endtask : t_single
   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   initial
   begin
      {i_clk, i_resetn, i_wr, i_rd, m_fail} = 5'h0;
      {i_addr, i_wdata, m_win} = 44'h0;
      {err_total, compares} = 64'h0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs;
      t_chip;
      t_prog;
      t_sect;
      t_more;
      t_fail;
      t_single;
      wrap_up;
   end
   initial
   begin
      #1000000;
      err_total++;
      wrap_up;
   end
endmodule : testbench
`default_nettype wire
